/* File: rtl/bmu_pkg.sv */
// Shared types and constants of the bit manipulation unit
package bmu_pkg;

    typedef enum logic [3:0] {
        bit_invert_op,
        bit_set_op,
        bit_test_op,
        bit_inverted_test_op,
        bit_test_clear_op,
        bit_or_carry_op,
        bit_nor_carry_op,
        bit_xnor_carry_op,
        debug_break_op
    } bmu_op_t;

    // Operand forms; the decoder has already extended the displacement
    typedef enum logic [2:0] {
        mode_reg_bit,
        mode_ind_a0,
        mode_ind_a1,
        mode_base_a0,
        mode_base_a1,
        mode_base_sb,
        mode_base_fb,
        mode_base11_sb
    } bmu_mode_t;

    typedef enum logic [3:0] {
        st_idle,
        st_mem_rd,
        st_exec,
        st_mem_wr,
        st_brk_hi,
        st_brk_lo,
        st_vec_lo,
        st_vec_hi,
        st_finish
    } bmu_state_t;

    // Flag register bit positions
    localparam int FLG_C = 0;
    localparam int FLG_D = 1;
    localparam int FLG_Z = 2;
    localparam int FLG_S = 3;
    localparam int FLG_B = 4;
    localparam int FLG_O = 5;
    localparam int FLG_I = 6;
    localparam int FLG_U = 7;

    localparam logic [7:0]  FLAGS_RST    = 8'h00;
    localparam logic [7:0]  BRK_CLR_MASK = 8'hC2;
    localparam logic [19:0] VEC_LO_ADDR  = 20'hF_FFE4;
    localparam logic [19:0] VEC_HI_ADDR  = 20'hF_FFE6;
    localparam logic [15:0] SP_STEP      = 16'h0002;
    localparam logic [19:0] PC_STEP      = 20'h0_0001;
    localparam logic [3:0]  ADDR_UPPER   = 4'h0;
    localparam logic [7:0]  BYTE_ZERO    = 8'h00;
    localparam int          BYTE_SHIFT   = 3;

endpackage

/* File: rtl/bmu_bit_logic.sv */
// Single-bit result and flag update for each bit operation
`timescale 1ns/100ps
module bmu_bit_logic
    import bmu_pkg::*;
(
    input  wire bmu_pkg::bmu_op_t op,
    input  wire logic             src_bit,
    input  wire logic [7:0]       flags_in,
    output logic                  bit_out,
    output logic                  bit_write,
    output logic [7:0]            flags_out,
    output logic                  flag_write
);

    always_comb begin
        bit_out    = src_bit;
        bit_write  = 1'b0;
        flags_out  = flags_in;
        flag_write = 1'b0;
        unique case (op)
            bit_invert_op: begin
                bit_out   = ~src_bit;
                bit_write = 1'b1;
            end
            bit_set_op: begin
                bit_out   = 1'b1;
                bit_write = 1'b1;
            end
            bit_test_op: begin
                flags_out[FLG_Z] = ~src_bit;
                flags_out[FLG_C] = src_bit;
                flag_write       = 1'b1;
            end
            bit_inverted_test_op: begin
                flags_out[FLG_Z] = ~src_bit;
                flags_out[FLG_C] = ~src_bit;
                flag_write       = 1'b1;
            end
            bit_test_clear_op: begin
                flags_out[FLG_Z] = ~src_bit;
                flags_out[FLG_C] = src_bit;
                flag_write       = 1'b1;
                bit_out          = 1'b0;
                bit_write        = 1'b1;
            end
            bit_or_carry_op: begin
                flags_out[FLG_C] = src_bit | flags_in[FLG_C];
                flag_write       = 1'b1;
            end
            bit_nor_carry_op: begin
                flags_out[FLG_C] = ~src_bit | flags_in[FLG_C];
                flag_write       = 1'b1;
            end
            bit_xnor_carry_op: begin
                flags_out[FLG_C] = ~src_bit ^ flags_in[FLG_C];
                flag_write       = 1'b1;
            end
            default: begin
                bit_write = 1'b0;
            end
        endcase
    end

endmodule

/* File: rtl/bmu_core.sv */
// Bit manipulation and debug break datapath of the CPU core
//
// Operation
// - Bit NOR-carry: carry becomes inverted source bit OR old carry.
// - Bit invert writes back complement of addressed bit; flags untouched.
// - Invert and set accept 11-bit static-base form only in short format.
// - Bit test accepts 11-bit static-base form only in short format.
// - Inverted test loads zero and carry with complement of source bit.
// - Bit XNOR-carry: carry becomes inverted source bit XOR old carry.
// - Bit OR-carry: carry becomes source bit OR old carry.
// - Break pushes PC high with flags, then PC low, loads vector.
// - Debug break is taken regardless of interrupt enable or level.
// - Break saves flags first; only stack, enable, debug flags change.
// - Bit set writes one into addressed bit; flags untouched.
// - Bit test: zero gets inverted source bit, carry gets source bit.
// - Test-and-clear updates zero and carry, then clears the bit.
// - Operands: register bit, indirect, or offset from register bases.
`timescale 1ns/100ps
module bmu_core (
    input  wire  logic                clk_sys,
    input  wire  logic                rst,
    input  wire  logic                start,
    input  wire  bmu_pkg::bmu_op_t    op,
    input  wire  bmu_pkg::bmu_mode_t  mode,
    input  wire  logic                short_format,
    input  wire  logic [3:0]          bit_num,
    input  wire  logic [15:0]         disp,
    input  wire  logic [15:0]         reg_operand,
    input  wire  logic [15:0]         addr_reg_zero,
    input  wire  logic [15:0]         addr_reg_one,
    input  wire  logic [15:0]         static_base_reg,
    input  wire  logic [15:0]         frame_base_reg,
    input  wire  logic [15:0]         stack_ptr_in,
    input  wire  logic [19:0]         pc_in,
    input  wire  logic [7:0]          flag_register,
    output logic                      busy,
    output logic                      done,
    output logic                      illegal,
    output logic [15:0]               reg_wdata,
    output logic                      reg_we,
    output logic [7:0]                flag_out,
    output logic                      flag_we,
    output logic [15:0]               stack_ptr_out,
    output logic                      stack_ptr_we,
    output logic [19:0]               pc_out,
    output logic                      pc_we,
    output logic                      mem_req,
    output logic                      mem_we,
    output logic                      mem_word,
    output logic                      mem_lock,
    output logic [19:0]               mem_addr,
    output logic [15:0]               mem_wdata,
    input  wire  logic [15:0]         mem_rdata,
    input  wire  logic                mem_ack
);
    import bmu_pkg::*;

    bmu_state_t  state, next_state;
    bmu_op_t     op_q, next_op_q;
    logic [15:0] data_q, next_data_q;
    logic [3:0]  bit_q, next_bit_q;
    logic        is_mem_q, next_is_mem_q;
    logic        src_bit_q, next_src_bit_q;
    logic        fw_q, next_fw_q;
    logic        rw_q, next_rw_q;
    logic        ill_q, next_ill_q;
    logic [7:0]  old_flags_q, next_old_flags_q;
    logic [7:0]  flags_q, next_flags_q;
    logic [15:0] sp_q, next_sp_q;
    logic [19:0] pc_q, next_pc_q;
    logic        next_mem_req, next_mem_we, next_mem_word;
    logic [19:0] next_mem_addr;
    logic [15:0] next_mem_wdata;

    logic [15:0] bit_addr, byte_off;
    logic [3:0]  bit_idx;
    logic        form_bad;
    logic        lg_bit, lg_wr, lg_fw;
    logic [7:0]  lg_flags;

    bmu_bit_logic u_logic (
        .op         (op_q),
        .src_bit    (data_q[bit_q]),
        .flags_in   (old_flags_q),
        .bit_out    (lg_bit),
        .bit_write  (lg_wr),
        .flags_out  (lg_flags),
        .flag_write (lg_fw)
    );

    // Operand location from the addressing form
    always_comb begin
        bit_addr = 16'h0000;
        byte_off = 16'h0000;
        bit_idx  = bit_num;
        unique case (mode)
            mode_reg_bit: bit_idx = bit_num;
            mode_ind_a0:  bit_addr = addr_reg_zero;
            mode_ind_a1:  bit_addr = addr_reg_one;
            mode_base_a0: bit_addr = disp + addr_reg_zero;
            mode_base_a1: bit_addr = disp + addr_reg_one;
            mode_base_sb, mode_base11_sb: begin
                byte_off = disp + static_base_reg;
                bit_idx  = {1'b0, bit_num[2:0]};
            end
            mode_base_fb: begin
                byte_off = disp + frame_base_reg;
                bit_idx  = {1'b0, bit_num[2:0]};
            end
        endcase
        if (mode inside {mode_ind_a0, mode_ind_a1, mode_base_a0,
                         mode_base_a1}) begin
            // Address register forms carry a bit address, not a byte one
            byte_off = bit_addr >> BYTE_SHIFT;
            bit_idx  = {1'b0, bit_addr[2:0]};
        end
        // 11-bit static-base form exists only for short invert/set/test
        form_bad = (mode == mode_base11_sb) &&
                   (!short_format ||
                    !(op inside {bit_invert_op, bit_set_op,
                                 bit_test_op}));
    end

    always_comb begin
        next_state       = state;
        next_op_q        = op_q;
        next_data_q      = data_q;
        next_bit_q       = bit_q;
        next_is_mem_q    = is_mem_q;
        next_src_bit_q   = src_bit_q;
        next_fw_q        = fw_q;
        next_rw_q        = rw_q;
        next_ill_q       = 1'b0;
        next_old_flags_q = old_flags_q;
        next_flags_q     = flags_q;
        next_sp_q        = sp_q;
        next_pc_q        = pc_q;
        next_mem_req     = mem_req;
        next_mem_we      = mem_we;
        next_mem_word    = mem_word;
        next_mem_addr    = mem_addr;
        next_mem_wdata   = mem_wdata;
        unique case (state)
            st_idle: begin
                if (start) begin
                    next_op_q        = op;
                    next_old_flags_q = flag_register;
                    next_flags_q     = flag_register;
                    next_fw_q        = 1'b0;
                    next_rw_q        = 1'b0;
                    if (op == debug_break_op) begin
                        // Interrupt enable and level are not consulted
                        next_sp_q      = stack_ptr_in - SP_STEP;
                        next_pc_q      = pc_in + PC_STEP;
                        next_mem_req   = 1'b1;
                        next_mem_we    = 1'b1;
                        next_mem_word  = 1'b1;
                        next_mem_addr  = {ADDR_UPPER,
                                          stack_ptr_in - SP_STEP};
                        next_mem_wdata = {ADDR_UPPER,
                                          next_pc_q[19:16],
                                          flag_register};
                        next_state     = st_brk_hi;
                    end else if (form_bad) begin
                        next_ill_q = 1'b1;
                    end else begin
                        next_bit_q    = bit_idx;
                        next_is_mem_q = (mode != mode_reg_bit);
                        if (mode == mode_reg_bit) begin
                            next_data_q = reg_operand;
                            next_state  = st_exec;
                        end else begin
                            next_mem_req  = 1'b1;
                            next_mem_we   = 1'b0;
                            next_mem_word = 1'b0;
                            next_mem_addr = {ADDR_UPPER, byte_off};
                            next_state    = st_mem_rd;
                        end
                    end
                end
            end
            st_mem_rd: begin
                if (mem_ack) begin
                    next_mem_req = 1'b0;
                    next_data_q  = {BYTE_ZERO, mem_rdata[7:0]};
                    next_state   = st_exec;
                end
            end
            st_exec: begin
                next_src_bit_q = data_q[bit_q];
                next_flags_q   = lg_flags;
                next_fw_q      = lg_fw;
                if (lg_wr) begin
                    next_data_q[bit_q] = lg_bit;
                end
                next_rw_q  = lg_wr && !is_mem_q;
                next_state = st_finish;
                if (lg_wr && is_mem_q) begin
                    // Write back the byte while the lock is still held
                    next_mem_req   = 1'b1;
                    next_mem_we    = 1'b1;
                    next_mem_wdata = next_data_q;
                    next_state     = st_mem_wr;
                end
            end
            st_mem_wr: begin
                if (mem_ack) begin
                    next_mem_req = 1'b0;
                    next_mem_we  = 1'b0;
                    next_state   = st_finish;
                end
            end
            st_brk_hi: begin
                if (mem_ack) begin
                    next_sp_q      = sp_q - SP_STEP;
                    next_mem_addr  = {ADDR_UPPER, sp_q - SP_STEP};
                    next_mem_wdata = pc_q[15:0];
                    next_state     = st_brk_lo;
                end
            end
            st_brk_lo: begin
                if (mem_ack) begin
                    next_mem_we   = 1'b0;
                    next_mem_addr = VEC_LO_ADDR;
                    next_state    = st_vec_lo;
                end
            end
            st_vec_lo: begin
                if (mem_ack) begin
                    next_pc_q[15:0] = mem_rdata;
                    next_mem_word   = 1'b0;
                    next_mem_addr   = VEC_HI_ADDR;
                    next_state      = st_vec_hi;
                end
            end
            st_vec_hi: begin
                if (mem_ack) begin
                    next_pc_q[19:16] = mem_rdata[3:0];
                    next_mem_req     = 1'b0;
                    // Flags were pushed already; now clear U, I and D
                    next_flags_q     = old_flags_q &
                                       ~BRK_CLR_MASK;
                    next_fw_q        = 1'b1;
                    next_state       = st_finish;
                end
            end
            st_finish: begin
                next_state = st_idle;
            end
            default: begin
                next_state = st_idle;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state       <= st_idle;
            op_q        <= bit_invert_op;
            data_q      <= 16'h0000;
            bit_q       <= 4'h0;
            is_mem_q    <= 1'b0;
            src_bit_q   <= 1'b0;
            fw_q        <= 1'b0;
            rw_q        <= 1'b0;
            ill_q       <= 1'b0;
            old_flags_q <= FLAGS_RST;
            flags_q     <= FLAGS_RST;
            sp_q        <= 16'h0000;
            pc_q        <= 20'h0_0000;
            mem_req     <= 1'b0;
            mem_we      <= 1'b0;
            mem_word    <= 1'b0;
            mem_addr    <= 20'h0_0000;
            mem_wdata   <= 16'h0000;
        end else begin
            state       <= next_state;
            op_q        <= next_op_q;
            data_q      <= next_data_q;
            bit_q       <= next_bit_q;
            is_mem_q    <= next_is_mem_q;
            src_bit_q   <= next_src_bit_q;
            fw_q        <= next_fw_q;
            rw_q        <= next_rw_q;
            ill_q       <= next_ill_q;
            old_flags_q <= next_old_flags_q;
            flags_q     <= next_flags_q;
            sp_q        <= next_sp_q;
            pc_q        <= next_pc_q;
            mem_req     <= next_mem_req;
            mem_we      <= next_mem_we;
            mem_word    <= next_mem_word;
            mem_addr    <= next_mem_addr;
            mem_wdata   <= next_mem_wdata;
        end
    end

    assign busy          = (state != st_idle);
    assign done          = (state == st_finish);
    assign illegal       = ill_q;
    assign reg_wdata     = data_q;
    assign reg_we        = done && rw_q;
    assign flag_out      = flags_q;
    assign flag_we       = done && fw_q;
    assign stack_ptr_out = sp_q;
    assign pc_out        = pc_q;
    assign stack_ptr_we  = done && (op_q == debug_break_op);
    assign pc_we         = done && (op_q == debug_break_op);
    assign mem_lock      = state inside {st_mem_rd, st_exec, st_mem_wr};

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_lo_acked;
        state == st_brk_lo && mem_ack;
    endsequence
    sequence s_vec_read;
        mem_req && !mem_we && mem_word && mem_addr == VEC_LO_ADDR;
    endsequence

    a_nor_carry_out: assert property (
        done && op_q == bit_nor_carry_op |-> flag_we &&
        flag_out[FLG_C] == (!src_bit_q || old_flags_q[FLG_C]) &&
        flag_out[7:1] == old_flags_q[7:1])
        else $error("nor carry result wrong");
    a_invert_write: assert property (
        done && op_q == bit_invert_op |->
        !flag_we && reg_wdata[bit_q] == !src_bit_q)
        else $error("invert result wrong");
    a_short_form_only: assert property (
        start && state == st_idle && op != debug_break_op &&
        mode == mode_base11_sb && !short_format |=>
        illegal && state == st_idle)
        else $error("long 11-bit form accepted");
    a_inv_test_flags: assert property (
        done && op_q == bit_inverted_test_op |-> flag_we &&
        flag_out[FLG_Z] == !src_bit_q && flag_out[FLG_C] == !src_bit_q)
        else $error("inverted test flags wrong");
    a_xnor_carry_out: assert property (
        done && op_q == bit_xnor_carry_op |-> flag_we &&
        flag_out[FLG_C] == (!src_bit_q ^ old_flags_q[FLG_C]) &&
        flag_out[7:1] == old_flags_q[7:1])
        else $error("xnor carry result wrong");
    a_or_carry_out: assert property (
        done && op_q == bit_or_carry_op |-> flag_we &&
        flag_out[FLG_C] == (src_bit_q || old_flags_q[FLG_C]) &&
        flag_out[7:1] == old_flags_q[7:1])
        else $error("or carry result wrong");
    a_brk_vector_read: assert property (
        s_lo_acked |=> s_vec_read)
        else $error("vector fetch not issued");
    a_brk_push_order: assert property (
        state == st_brk_hi |-> mem_we && mem_wdata[7:0] == old_flags_q
        ##[1:1000] state == st_brk_lo && mem_wdata == pc_q[15:0])
        else $error("break push wrong");
    a_brk_nonmask: assert property (
        start && state == st_idle && op == debug_break_op |=>
        state == st_brk_hi && mem_req)
        else $error("break not taken");
    a_brk_flag_clear: assert property (
        done && op_q == debug_break_op |->
        flag_we && flag_out == (old_flags_q & ~BRK_CLR_MASK))
        else $error("break flags wrong");
    a_set_no_flags: assert property (
        done && op_q == bit_set_op |-> !flag_we && reg_wdata[bit_q])
        else $error("set result wrong");
    a_test_flags: assert property (
        done && op_q == bit_test_op |-> flag_we && !reg_we &&
        flag_out[FLG_Z] == !src_bit_q && flag_out[FLG_C] == src_bit_q)
        else $error("test flags wrong");
    a_test_clear_wr: assert property (
        state == st_mem_wr && op_q == bit_test_clear_op |->
        !mem_wdata[bit_q[2:0]] && flags_q[FLG_C] == src_bit_q &&
        flags_q[FLG_Z] == !src_bit_q)
        else $error("test clear result wrong");
    a_rmw_locked: assert property (
        state == st_mem_wr && mem_req |-> mem_lock && mem_we &&
        !mem_word && $past(mem_lock, 2) &&
        mem_addr == $past(mem_addr, 2))
        else $error("write not inside lock");

endmodule

/* File: verif/tb_bit_manipulation_unit.sv */
// Self-checking bench for the bit manipulation unit, with a memory responder
`timescale 1ns/100ps
module tb_bit_manipulation_unit;
    import bmu_pkg::*;
    logic        clk_sys = 1'b0, rst = 1'b1, start = 1'b0;
    logic        short_format = 1'b0, mem_ack = 1'b0;
    bmu_op_t     op = bit_invert_op;
    bmu_mode_t   mode = mode_reg_bit;
    logic [3:0]  bit_num = 4'h0;
    logic [15:0] disp = 16'h0000, reg_operand = 16'h0000, a0 = 16'h0000;
    logic [15:0] sb = 16'h0000, fb = 16'h0000, sp = 16'h0000, a1 = 16'h0000;
    logic [15:0] mem_rdata = 16'h0000, reg_wdata, stack_ptr_out, mem_wdata;
    logic [19:0] pc = 20'h0_0000, pc_out, mem_addr;
    logic [7:0]  flags = 8'h00, flag_out;
    logic        busy, done, illegal, reg_we, flag_we, stack_ptr_we, pc_we;
    logic        mem_req, mem_we, mem_word, mem_lock;
    logic [53:0] log_q[$];
    int          lat = 0, bad_count = 0, total_checks = 0;

    bmu_core bmu_core_inst (.clk_sys(clk_sys), .rst(rst), .start(start),
        .op(op), .mode(mode), .short_format(short_format), .bit_num(bit_num),
        .disp(disp), .reg_operand(reg_operand), .addr_reg_zero(a0),
        .addr_reg_one(a1), .static_base_reg(sb), .frame_base_reg(fb),
        .stack_ptr_in(sp), .pc_in(pc), .flag_register(flags), .busy(busy),
        .done(done), .illegal(illegal), .reg_wdata(reg_wdata), .reg_we(reg_we),
        .flag_out(flag_out), .flag_we(flag_we), .stack_ptr_out(stack_ptr_out),
        .stack_ptr_we(stack_ptr_we), .pc_out(pc_out), .pc_we(pc_we),
        .mem_req(mem_req), .mem_we(mem_we), .mem_word(mem_word),
        .mem_lock(mem_lock), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .mem_ack(mem_ack));

    always #2 clk_sys = ~clk_sys;

    task automatic chk(input logic [63:0] seen, exp, input string msg);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL %0t %s", $time, msg);
        end
    endtask

    task automatic stop_test();
        if (bad_count == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Memory with random wait; read data scrambled outside the ack cycle
    always @(posedge clk_sys) begin
        #1;
        if (mem_ack) begin
            mem_ack = 1'b0;
            mem_rdata = ~mem_rdata;
        end else if (mem_req && lat > 0) begin
            lat--;
        end else if (mem_req) begin
            mem_ack = 1'b1;
            mem_rdata = 16'($urandom);
            lat = $urandom % 3;
            if (mem_we && !mem_word)
                chk(mem_lock, 1'b1, "lock dropped");
            log_q.push_back({mem_word, mem_we, mem_addr, mem_wdata,
                             mem_rdata});
        end
    end

    // Returns {bit written, new bit, flags written, new flags}
    function automatic logic [10:0] model(bmu_op_t o, logic b, logic [7:0] f);
        logic [7:0] n;
        n = f;
        case (o)
            bit_invert_op: return {2'b10 | {1'b0, ~b}, 1'b0, f};
            bit_set_op: return {2'b11, 1'b0, f};
            bit_test_op, bit_test_clear_op: begin
                n[FLG_Z] = ~b;
                n[FLG_C] = b;
            end
            bit_inverted_test_op: begin
                n[FLG_Z] = ~b;
                n[FLG_C] = ~b;
            end
            bit_or_carry_op: n[FLG_C] = b | f[FLG_C];
            bit_nor_carry_op: n[FLG_C] = ~b | f[FLG_C];
            default: n[FLG_C] = ~b ^ f[FLG_C];
        endcase
        return {o == bit_test_clear_op, 2'b01, n};
    endfunction

    task automatic run(input bmu_op_t o, input bmu_mode_t m, input logic s);
        int n;
        logic ill, b;
        logic [19:0] ba, rp;
        logic [2:0] bi;
        logic [10:0] e;
        logic [53:0] r;
        logic [15:0] w;
        logic [7:0] wb;
        ill = m == mode_base11_sb && (!s || !(o inside {bit_invert_op,
              bit_set_op, bit_test_op}));
        rp = pc + 20'h0_0001;
        w = (m inside {mode_ind_a1, mode_base_a1}) ? a1 : a0;
        if (m inside {mode_base_a0, mode_base_a1}) w = 16'(w + disp);
        ba = {4'h0, 16'(w >> 3)};
        bi = w[2:0];
        if (m inside {mode_base_sb, mode_base_fb, mode_base11_sb}) begin
            ba = {4'h0, 16'(disp + (m == mode_base_fb ? fb : sb))};
            bi = bit_num[2:0];
        end
        op = o;
        mode = m;
        short_format = s;
        start = 1'b1;
        @(posedge clk_sys);
        #1 start = 1'b0;
        n = 0;
        while (done !== 1'b1 && illegal !== 1'b1 && n < 60) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (ill) begin
            chk({illegal, done}, 2'b10, "form not refused");
        end else if (o == debug_break_op) begin
            chk({busy, done}, 2'b11, "break not taken");
            r = log_q.pop_front();
            chk(r[53:16], {2'b11, 4'h0, 16'(sp - 16'h0002), 4'h0, rp[19:16],
                flags}, "high push");
            r = log_q.pop_front();
            chk(r[53:16], {2'b11, 4'h0, 16'(sp - 16'h0004), rp[15:0]},
                "low push");
            r = log_q.pop_front();
            chk(r[53:32], {2'b10, 20'hF_FFE4}, "vector low");
            w = r[15:0];
            r = log_q.pop_front();
            chk(r[53:32], {2'b00, 20'hF_FFE6}, "vector high");
            chk({pc_we, pc_out}, {1'b1, r[3:0], w}, "vector");
            chk({stack_ptr_we, stack_ptr_out}, {1'b1, 16'(sp - 16'h0004)},
                "stack");
            chk({flag_we, flag_out}, {1'b1, flags & 8'h3D},
                "brk flags");
        end else begin
            wb = 8'h00;
            if (m == mode_reg_bit) begin
                b = reg_operand[bit_num];
                chk(n, 1, "latency");
            end else begin
                r = log_q.pop_front();
                chk(r[53:32], {2'b00, ba}, "read address");
                b = r[bi];
                wb = r[7:0];
            end
            e = model(o, b, flags);
            chk({busy, done, flag_we}, {2'b11, e[8]},
                "flag strobe");
            if (e[8])
                chk(flag_out, e[7:0],
                    "flags");
            if (m == mode_reg_bit) begin
                w = reg_operand;
                w[bit_num] = e[9];
                chk(reg_we, e[10], "reg strobe");
                if (e[10])
                    chk(reg_wdata, w, "reg data");
            end else if (e[10]) begin
                wb[bi] = e[9];
                r = log_q.pop_front();
                chk({r[53:32], r[23:16]}, {2'b01, ba, wb}, "write");
            end
        end
        chk(log_q.size(), 0, "stray access");
        @(posedge clk_sys);
        #1;
        chk({busy, done, illegal, mem_req, mem_lock, reg_we, flag_we, pc_we,
            stack_ptr_we}, 9'h000, "not idle");
    endtask

    initial begin
        #120000;
        bad_count++;
        stop_test();
    end

    initial begin
        void'($urandom(32'h21a3_4266));
        repeat (5) @(posedge clk_sys);
        #1 rst = 1'b0;
        for (int i = 0; i < 270; i++) begin
            reg_operand = 16'($urandom);
            a0 = 16'($urandom);
            a1 = 16'($urandom);
            sb = 16'($urandom);
            fb = 16'($urandom);
            disp = 16'($urandom);
            bit_num = 4'($urandom);
            flags = 8'($urandom);
            sp = 16'($urandom);
            pc = 20'($urandom);
            run(bmu_op_t'(i % 9),
                i % 9 == 8 ? mode_reg_bit : bmu_mode_t'(3'($urandom)),
                1'($urandom));
        end
        stop_test();
    end
endmodule
